// ---- pps_pkg.sv ----
// pps_pkg: constants and types of the power protection stage
`default_nettype none
package pps_pkg;
  // time base
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int PC_MS = 5;
  localparam logic [2:0] PC_TICKS = 3'(PC_MS / TICK_MS);
  localparam int PRE_TRIG_MS = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam int PRE_TRIG_N = PRE_TRIG_MS / PC_MS;
  localparam int PRE_FAULT_N = PRE_FAULT_MS / PC_MS;
  // widths and sizes
  localparam int PW = 26;
  localparam int HIST_N = 12;
  localparam int REC_W = 7;
  // reset ratios in percent of the threshold
  localparam logic signed [33:0] PCT = 34'sh64;
  localparam logic signed [33:0] RST_UNDER_PCT = 34'sh67;
  localparam logic signed [33:0] RST_REV_PCT = 34'sh61;
  localparam logic [16:0] RATIO_MAX = 17'h1E848;
  // register byte offsets; records start where address bit 9 is set
  localparam logic [9:0] ADR_CTRL = 10'h000;
  localparam logic [9:0] ADR_THR = 10'h004;
  localparam logic [9:0] ADR_LPB = 10'h008;
  localparam logic [9:0] ADR_OPD = 10'h00C;
  localparam logic [9:0] ADR_RSD = 10'h010;
  localparam logic [9:0] ADR_STAT = 10'h014;
  localparam logic [9:0] ADR_REM = 10'h018;
  localparam logic [9:0] ADR_RATIO = 10'h01C;
  localparam logic [9:0] ADR_CNT_S = 10'h020;
  localparam logic [9:0] ADR_CNT_T = 10'h024;
  localparam logic [9:0] ADR_CNT_B = 10'h028;
  localparam logic [9:0] ADR_TIME = 10'h02C;
  localparam logic [9:0] ADR_EXP = 10'h030;
  localparam logic [9:0] ADR_HPTR = 10'h034;
  localparam int HIST_BIT = 9;
  // control field positions
  localparam int CB_MODE = 0;
  localparam int CB_FEN = 1;
  localparam int CB_FST = 2;
  localparam int CB_ON = 4;
  localparam int CB_OFF = 5;
  localparam int CB_LPB = 6;
  localparam int CB_CLR = 7;
  localparam int CB_GRP = 8;
  // reset values
  localparam logic [23:0] THR_RST = 24'h002710;
  localparam logic [23:0] LPB_RST = 24'h001388;
  localparam logic [18:0] OPD_RST = 19'h00014;
  localparam logic [18:0] RSD_RST = 19'h00004;
  localparam logic [3:0] GRP_RST = 4'h1;
  // record fields and event names
  localparam int F_TIME = 0;
  localparam int F_EVT = 1;
  localparam int F_PRE = 2;
  localparam int F_FLT = 3;
  localparam int F_PREF = 4;
  localparam int F_REM = 5;
  localparam int F_GRP = 6;
  localparam logic [31:0] EV_START = 32'h00000000;
  localparam logic [31:0] EV_TRIP = 32'h00000001;
  localparam logic [31:0] EV_BLOCK = 32'h00000002;
  // condition codes as software sees them
  localparam logic [1:0] CC_NORMAL = 2'h0;
  localparam logic [1:0] CC_START = 2'h1;
  localparam logic [1:0] CC_TRIP = 2'h2;
  localparam logic [1:0] CC_BLOCKED = 2'h3;
  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1,
    ST_START = 4'h2,
    ST_TRIP = 4'h4,
    ST_BLOCKED = 4'h8
  } pps_state_t;
endpackage
`default_nettype wire

// ---- pps_stage.sv ----
// pps_stage: single under/reverse power protection stage with avalon-mm registers
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - condition is always exactly one of normal, start, trip, blocked
// - expected operating time readable, 5 ms steps, up to 1800 s
// - signed remaining time to trip shown while counting, 5 ms steps
// - ratio of measured power to threshold shown continuously in hundredths
// - blocking input sampled at the start of every program cycle
// - pick-up without block asserts start and begins operate timing
// - pick-up with block asserts blocked and nothing further
// - block during start clears start and runs release timing; code runs it only once pick-up drops, else goes blocked holding op_cnt
// - operate and reset delays are definite time only
// - on/off events for start, trip, block; selectable on, off, both
// - each event carries a time stamp taken at the change
// - separate resettable counters of start, trip and blocked
// - one independent stage with one set of settings and outputs
// - each on event writes a record; last twelve kept, oldest overwritten
// - record: time, event, power -20 ms, fault, -200 ms, remaining, group
// - force status overrides condition, only with forcing enabled
// - force setting is static, untouched by setting group changes
// - active power from three phase fundamental components
// - under-power pick-up releases above 103 % of threshold
// - reverse power pick-up releases below 97 % of threshold
// - low power inhibit holds off tripping until power exceeds reset value
module pps_stage
  import pps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [9:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_block,
  input wire logic signed [23:0] i_phase_p1,
  input wire logic signed [23:0] i_phase_p2,
  input wire logic signed [23:0] i_phase_p3,
  output logic [1:0] o_cond,
  output logic o_start,
  output logic o_trip,
  output logic o_blocked,
  output logic signed [19:0] o_remain,
  output logic [16:0] o_ratio,
  output logic [5:0] o_evt,
  output logic [31:0] o_evt_time
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] blk_sync;
    logic blk_s;
    logic [15:0] ms_div;
    logic [2:0] pc_div;
    logic pc_tick;
    logic [31:0] time_ms;
    logic mode;
    logic force_en;
    logic [1:0] force_st;
    logic on_en;
    logic off_en;
    logic lpb_en;
    logic [3:0] grp;
    logic [23:0] thr;
    logic [23:0] lpb_thr;
    logic [18:0] op_dly;
    logic [18:0] rst_dly;
    logic pickup;
    logic low_power_inhibit;
    pps_state_t state;
    logic [18:0] op_cnt;
    logic [18:0] rel_cnt;
    logic [2:0][31:0] cnt;
    logic [PRE_FAULT_N-1:0][PW-1:0] pwr_hist;
    logic [PW-1:0] pre_fault;
    logic [3:0] hptr;
    logic [HIST_N-1:0][REC_W-1:0][31:0] hist;
    logic waitreq;
    logic [31:0] rdata;
    logic [1:0] cond;
    logic start;
    logic trip;
    logic blocked;
    logic [19:0] remain;
    logic [16:0] ratio;
    logic [5:0] evt;
    logic [31:0] evt_time;
  } pps_regs_t;

  pps_regs_t r;
  pps_regs_t n;

  function automatic logic [1:0] pps_code(input pps_state_t s);
    logic [1:0] c;
    c = CC_NORMAL;
    unique case (s)
      ST_NORMAL: c = CC_NORMAL;
      ST_START: c = CC_START;
      ST_TRIP: c = CC_TRIP;
      ST_BLOCKED: c = CC_BLOCKED;
    endcase
    return c;
  endfunction

  // ----------------------------------------
  // measurement and bus decode
  // ----------------------------------------
  logic signed [PW-1:0] psum;
  logic signed [33:0] m34;
  logic signed [33:0] m100;
  logic signed [33:0] thr34;
  logic signed [33:0] lpb34;
  logic signed [33:0] t103;
  logic signed [33:0] t97;
  logic [33:0] ratio_q;
  logic [16:0] ratio_c;
  logic [31:0] rd_word;
  logic [31:0] bmask;
  logic [31:0] wm;
  logic wr_en;
  logic [3:0] rec;
  logic [2:0] fld;

  assign psum = PW'(i_phase_p1) + PW'(i_phase_p2) + PW'(i_phase_p3);
  // reverse mode works on the negated power so both modes compare against the positive threshold
  assign m34 = r.mode ? -34'(psum) : 34'(psum);
  assign m100 = m34 * PCT;
  assign thr34 = $signed({10'h000, r.thr});
  assign lpb34 = $signed({10'h000, r.lpb_thr});
  assign t103 = thr34 * RST_UNDER_PCT;
  assign t97 = thr34 * RST_REV_PCT;
  // a combinational divider is large but keeps the ratio current every cycle
  assign ratio_q = (m34 <= 34'sh0 || r.thr == 24'h000000) ? 34'h0 :
                   $unsigned(m100) / {10'h000, r.thr};
  assign ratio_c = (ratio_q > 34'(RATIO_MAX)) ? RATIO_MAX : ratio_q[16:0];
  assign rec = i_address[8:5];
  assign fld = i_address[4:2];
  assign bmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                  {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  assign wm = (rd_word & ~bmask) | (i_writedata & bmask);
  assign wr_en = i_write & ~r.waitreq;

  always_comb begin
    rd_word = 32'h00000000;
    if (i_address[HIST_BIT]) begin
      if (rec < 4'(HIST_N) && fld < 3'(REC_W)) begin
        rd_word = r.hist[rec][fld];
      end
    end else begin
      case (i_address)
        ADR_CTRL: begin
          rd_word[CB_MODE] = r.mode;
          rd_word[CB_FEN] = r.force_en;
          rd_word[CB_FST +: 2] = r.force_st;
          rd_word[CB_ON] = r.on_en;
          rd_word[CB_OFF] = r.off_en;
          rd_word[CB_LPB] = r.lpb_en;
          rd_word[CB_GRP +: 4] = r.grp;
        end
        ADR_THR: rd_word = {8'h00, r.thr};
        ADR_LPB: rd_word = {8'h00, r.lpb_thr};
        ADR_OPD: rd_word = {13'h0000, r.op_dly};
        ADR_RSD: rd_word = {13'h0000, r.rst_dly};
        ADR_STAT: rd_word = {27'h0000000, r.blk_s, r.low_power_inhibit, r.pickup, r.cond};
        ADR_REM: rd_word = 32'($signed(r.remain));
        ADR_RATIO: rd_word = {15'h0000, r.ratio};
        ADR_CNT_S: rd_word = r.cnt[0];
        ADR_CNT_T: rd_word = r.cnt[1];
        ADR_CNT_B: rd_word = r.cnt[2];
        ADR_TIME: rd_word = r.time_ms;
        ADR_EXP: rd_word = {13'h0000, r.op_dly};
        ADR_HPTR: rd_word = {28'h0000000, r.hptr};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic eff;
    logic [2:0] f;
    logic [2:0] rise;
    logic [2:0] fall;
    eff = 1'b0;
    f = 3'h0;
    rise = 3'h0;
    fall = 3'h0;
    n = r;
    n.blk_sync = {r.blk_sync[0], i_block};
    n.pc_tick = 1'b0;
    n.evt = 6'h00;
    // millisecond time base and 5 ms program cycle
    if (r.ms_div == 16'(TICK_CYCLES - 1)) begin
      n.ms_div = 16'h0000;
      n.time_ms = r.time_ms + 32'h00000001;
      if (r.pc_div == PC_TICKS - 3'h1) begin
        n.pc_div = 3'h0;
        n.pc_tick = 1'b1;
      end else begin
        n.pc_div = r.pc_div + 3'h1;
      end
    end else begin
      n.ms_div = r.ms_div + 16'h0001;
    end
    // two-cycle slave: answer one cycle after the request, commit on release
    n.waitreq = ~((i_read | i_write) & r.waitreq);
    if ((i_read | i_write) & r.waitreq) begin
      n.rdata = rd_word;
    end
    if (wr_en) begin
      case (i_address)
        ADR_CTRL: begin
          n.mode = wm[CB_MODE];
          n.force_en = wm[CB_FEN];
          n.force_st = wm[CB_FST +: 2];
          n.on_en = wm[CB_ON];
          n.off_en = wm[CB_OFF];
          n.lpb_en = wm[CB_LPB];
          n.grp = wm[CB_GRP +: 4];
          if (wm[CB_CLR]) begin
            n.cnt = '0;
          end
        end
        ADR_THR: n.thr = wm[23:0];
        ADR_LPB: n.lpb_thr = wm[23:0];
        ADR_OPD: n.op_dly = wm[18:0];
        ADR_RSD: n.rst_dly = wm[18:0];
        default: n.thr = r.thr;
      endcase
    end
    if (r.pc_tick) begin
      n.blk_s = r.blk_sync[1];
      n.pwr_hist = {r.pwr_hist[PRE_FAULT_N-2:0], psum};
      if (r.mode) begin
        n.pickup = r.pickup ? !(m100 < t97) : (m34 > thr34);
      end else begin
        n.pickup = r.pickup ? !(m100 > t103) : (m34 < thr34);
      end
      // the inhibit only exists in under-power mode
      n.low_power_inhibit = !r.mode && r.lpb_en && (r.low_power_inhibit ? !(m100 > t103) : (m34 < lpb34));
      eff = n.blk_s | n.low_power_inhibit;
      // definite-time operate and reset counters in 5 ms steps
      unique case (r.state)
        ST_NORMAL: begin
          if (n.pickup) begin
            n.rel_cnt = 19'h00000;
            n.state = eff ? ST_BLOCKED : ST_START;
          end else if (r.op_cnt != 19'h00000) begin
            if (r.rel_cnt + 19'h00001 >= r.rst_dly) begin
              n.op_cnt = 19'h00000;
              n.rel_cnt = 19'h00000;
            end else begin
              n.rel_cnt = r.rel_cnt + 19'h00001;
            end
          end
        end
        ST_START: begin
          if (eff || !n.pickup) begin
            n.state = ST_NORMAL;
            n.rel_cnt = 19'h00000;
          end else if (r.op_cnt + 19'h00001 >= r.op_dly) begin
            n.state = ST_TRIP;
            n.op_cnt = r.op_dly;
          end else begin
            n.op_cnt = r.op_cnt + 19'h00001;
          end
        end
        ST_TRIP: begin
          if (n.pickup) begin
            n.rel_cnt = 19'h00000;
          end else if (r.rel_cnt + 19'h00001 >= r.rst_dly) begin
            n.state = ST_NORMAL;
            n.op_cnt = 19'h00000;
            n.rel_cnt = 19'h00000;
          end else begin
            n.rel_cnt = r.rel_cnt + 19'h00001;
          end
        end
        ST_BLOCKED: begin
          if (!n.pickup || !eff) begin
            n.state = ST_NORMAL;
          end
        end
      endcase
    end
    n.remain = (n.state == ST_START) ?
               20'({1'b0, r.op_dly} - {1'b0, n.op_cnt}) : 20'h00000;
    n.ratio = ratio_c;
    // forcing overrides what the outside sees, never the timers
    n.cond = r.force_en ? r.force_st : pps_code(n.state);
    f = {n.cond == CC_BLOCKED, n.cond == CC_TRIP, n.cond == CC_START};
    rise = f & ~{r.blocked, r.trip, r.start};
    fall = ~f & {r.blocked, r.trip, r.start};
    n.start = f[0];
    n.trip = f[1];
    n.blocked = f[2];
    n.evt = {fall & {3{r.off_en}}, rise & {3{r.on_en}}};
    if (|(rise | fall)) begin
      n.evt_time = r.time_ms;
    end
    // counting after a same-cycle clear keeps the new occurrence
    for (int i = 0; i < 3; i++) begin
      if (rise[i]) begin
        n.cnt[i] = n.cnt[i] + 32'h00000001;
      end
    end
    if (rise[0]) begin
      n.pre_fault = r.pwr_hist[PRE_FAULT_N-1];
    end
    // one record per cycle; trip outranks block outranks start
    if (|rise) begin
      n.hist[r.hptr][F_TIME] = r.time_ms;
      n.hist[r.hptr][F_EVT] = rise[1] ? EV_TRIP : (rise[2] ? EV_BLOCK : EV_START);
      n.hist[r.hptr][F_PRE] = 32'($signed(r.pwr_hist[PRE_TRIG_N-1]));
      n.hist[r.hptr][F_FLT] = 32'(psum);
      n.hist[r.hptr][F_PREF] = rise[0] ? 32'($signed(r.pwr_hist[PRE_FAULT_N-1])) :
                                         32'($signed(r.pre_fault));
      n.hist[r.hptr][F_REM] = 32'($signed(n.remain));
      n.hist[r.hptr][F_GRP] = {28'h0000000, r.grp};
      n.hptr = (r.hptr == 4'(HIST_N - 1)) ? 4'h0 : r.hptr + 4'h1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      r.waitreq <= 1'b1;
      r.state <= ST_NORMAL;
      r.on_en <= 1'b1;
      r.off_en <= 1'b1;
      r.grp <= GRP_RST;
      r.thr <= THR_RST;
      r.lpb_thr <= LPB_RST;
      r.op_dly <= OPD_RST;
      r.rst_dly <= RSD_RST;
    end else begin
      r <= n;
    end
  end

  assign o_readdata = r.rdata;
  assign o_waitrequest = r.waitreq;
  assign o_cond = r.cond;
  assign o_start = r.start;
  assign o_trip = r.trip;
  assign o_blocked = r.blocked;
  assign o_remain = r.remain;
  assign o_ratio = r.ratio;
  assign o_evt = r.evt;
  assign o_evt_time = r.evt_time;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  state_onehot_a: assert property ($onehot(r.state))
    else $error("stage state not one-hot");
  exp_read_a: assert property (i_read && r.waitreq && i_address == ADR_EXP
    |=> o_readdata == {13'h0000, r.op_dly})
    else $error("expected time read wrong");
  remain_idle_a: assert property (r.state != ST_START |-> o_remain == 20'h00000)
    else $error("remaining time outside start");
  ratio_cap_a: assert property (o_ratio <= RATIO_MAX)
    else $error("ratio beyond range");
  blk_sample_a: assert property (!r.pc_tick |=> $stable(r.blk_s))
    else $error("block sampled off cycle start");
  blocked_hold_a: assert property (r.state == ST_BLOCKED |-> r.blk_s || r.low_power_inhibit)
    else $error("blocked without block");
  start_drop_a: assert property (r.pc_tick && r.state == ST_START &&
    r.blk_sync[1] |=> r.state == ST_NORMAL)
    else $error("start kept under block");
  trip_from_a: assert property ($rose(r.state == ST_TRIP) |->
    $past(r.state) == ST_START && $past(r.op_cnt) + 19'h00001 >= r.op_dly)
    else $error("trip not after timing");
  evt_on_a: assert property (|o_evt[2:0] |-> $past(r.on_en))
    else $error("on event while disabled");
  hist_ptr_a: assert property (r.hptr < 4'(HIST_N))
    else $error("record pointer out of range");
  force_a: assert property (r.force_en |=> o_cond == $past(r.force_st))
    else $error("forced condition not shown");

endmodule
`default_nettype wire

// ---- pps_far_model.sv ----
// pps_far_model: blocking matrix and three-phase measurement front end
`timescale 1ns/1ps
`default_nettype none
module pps_far_model (
  input wire logic i_clk,
  input wire logic i_block_req,
  input wire logic signed [23:0] i_total,
  output logic o_block,
  output logic signed [23:0] o_phase_p1,
  output logic signed [23:0] o_phase_p2,
  output logic signed [23:0] o_phase_p3
);
  initial begin
    o_block = 1'b0;
    o_phase_p1 = 24'sh000000;
    o_phase_p2 = 24'sh000000;
    o_phase_p3 = 24'sh000000;
  end
  // ----------------------------------------
  // block and phase outputs
  // ----------------------------------------
  // block follows the request one clock later; the bench raises it whole program
  // cycles before any operate delay runs out, so the stage sees it in time
  always @(posedge i_clk) begin
    o_block <= i_block_req;
    // remainder goes to the third phase so the summed power stays exact
    o_phase_p1 <= i_total / 24'sd3;
    o_phase_p2 <= i_total / 24'sd3;
    o_phase_p3 <= i_total - 24'sd2 * (i_total / 24'sd3);
  end
endmodule
`default_nettype wire

// ---- pps_stage_bench.sv ----
// pps_stage_bench: register and protection sequence bench of the power stage
`timescale 1ns/1ps
`default_nettype none
module pps_stage_bench;
  import pps_pkg::*;
  // short millisecond so a program cycle is 20 clocks
  localparam int unsigned TK = 4;
  localparam int PC = TK * 5;
  logic i_clk, i_resetn, i_read, i_write, i_block, blk;
  logic o_waitrequest, o_start, o_trip, o_blocked;
  logic [9:0] i_address;
  logic [31:0] i_writedata, o_readdata, o_evt_time, rd;
  logic [3:0] i_byteenable;
  logic signed [23:0] pw, i_phase_p1, i_phase_p2, i_phase_p3;
  logic [1:0] o_cond;
  logic signed [19:0] o_remain;
  logic [16:0] o_ratio;
  logic [5:0] o_evt, ev;
  int mismatches, samples_checked, n;
  pps_stage #(.TICK_CYCLES(TK)) dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_block(i_block), .i_phase_p1(i_phase_p1),
    .i_phase_p2(i_phase_p2), .i_phase_p3(i_phase_p3), .o_cond(o_cond),
    .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked), .o_remain(o_remain),
    .o_ratio(o_ratio), .o_evt(o_evt), .o_evt_time(o_evt_time));
  pps_far_model far (.i_clk(i_clk), .i_block_req(blk), .i_total(pw), .o_block(i_block),
    .o_phase_p1(i_phase_p1), .o_phase_p2(i_phase_p2), .o_phase_p3(i_phase_p3));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // event pulses last one clock; gathered mid-cycle so no race with the checks
  always @(negedge i_clk) ev = ev | o_evt;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= ~wr;
    @(posedge i_clk);
    // only the watchdog ends a wait that never gets its answer
    while (o_waitrequest !== 1'b0) begin
      @(posedge i_clk);
    end
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic waitc(input logic [1:0] c, input int lim);
    n = 0;
    while (o_cond !== c && n < lim) begin
      @(posedge i_clk);
      n++;
    end
    chk(32'(o_cond), 32'(c));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(20000 * 25);
    mismatches++;
    test_done();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    i_resetn = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 10'h000;
    i_writedata = 32'h0;
    i_byteenable = 4'hF;
    blk = 1'b0;
    pw = 24'sh002EE0;
    ev = 6'h00;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rdc(ADR_THR, 32'h00002710);
    rdc(ADR_OPD, 32'h00000014);
    rdc(ADR_EXP, 32'h00000014);
    rdc(ADR_STAT, 32'h00000000);
    rdc(ADR_CNT_T, 32'h00000000);
    rdc(ADR_HPTR, 32'h00000000);
    rdc(10'h03C, 32'h00000000);
    bus(1'b1, ADR_EXP, 32'h00000099);
    rdc(ADR_EXP, 32'h00000014);
    bus(1'b1, ADR_OPD, 32'h00000004);
    rdc(ADR_EXP, 32'h00000004);
    // let the pre-fault history fill with a healthy level first
    repeat (45 * PC) @(posedge i_clk);
    chk(32'(o_ratio), 32'h00000078);
    rdc(ADR_RATIO, 32'h00000078);
    ev = 6'h00;
    pw <= 24'sh001F40;
    waitc(CC_START, 3 * PC);
    chk(32'(ev), 32'h00000001);
    chk(32'(o_start && !o_trip && !o_blocked), 32'h1);
    chk(32'(o_remain > 0 && o_remain <= 4), 32'h1);
    ev = 6'h00;
    waitc(CC_TRIP, 6 * PC);
    chk(32'(n >= 2 * PC && n <= 5 * PC), 32'h1);
    chk(32'(ev), 32'h0000000A);
    bus(1'b0, ADR_TIME, 32'h0);
    chk(32'(o_evt_time <= rd && rd - o_evt_time < 8), 32'h1);
    rdc(ADR_CNT_S, 32'h00000001);
    rdc(ADR_CNT_T, 32'h00000001);
    rdc(ADR_HPTR, 32'h00000002);
    rdc(10'h204, EV_START);
    rdc(10'h224, EV_TRIP);
    rdc(10'h208, 32'h00002EE0);
    rdc(10'h20C, 32'h00001F40);
    rdc(10'h210, 32'h00002EE0);
    rdc(10'h218, 32'h00000001);
    // inside the hysteresis band the trip must hold
    pw <= 24'sh0027D8;
    repeat (8 * PC) @(posedge i_clk);
    chk(32'(o_cond), 32'(CC_TRIP));
    ev = 6'h00;
    pw <= 24'sh0028A0;
    waitc(CC_NORMAL, 8 * PC);
    chk(32'(ev), 32'h00000010);
    blk <= 1'b1;
    repeat (2 * PC) @(posedge i_clk);
    ev = 6'h00;
    pw <= 24'sh001F40;
    waitc(CC_BLOCKED, 3 * PC);
    chk(32'(ev), 32'h00000004);
    repeat (6 * PC) @(posedge i_clk);
    chk(32'(o_cond), 32'(CC_BLOCKED));
    rdc(ADR_CNT_B, 32'h00000001);
    rdc(10'h244, EV_BLOCK);
    blk <= 1'b0;
    waitc(CC_START, 4 * PC);
    ev = 6'h00;
    blk <= 1'b1;
    waitc(CC_NORMAL, 3 * PC);
    chk(32'(ev[3]), 32'h1);
    repeat (6 * PC) @(posedge i_clk);
    chk(32'(o_trip), 32'h0);
    blk <= 1'b0;
    pw <= 24'sh002EE0;
    waitc(CC_NORMAL, 8 * PC);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, ADR_CTRL, 32'h00000132 | (32'(c) << 2));
      waitc(2'(c), 2 * PC);
    end
    bus(1'b1, ADR_CTRL, 32'h0000013C);
    waitc(CC_NORMAL, 2 * PC);
    bus(1'b1, ADR_CTRL, 32'h00000236);
    waitc(CC_START, 2 * PC);
    bus(1'b1, ADR_CTRL, 32'h000001B0);
    repeat (2 * PC) @(posedge i_clk);
    rdc(ADR_CNT_S, 32'h00000000);
    rdc(ADR_CNT_B, 32'h00000000);
    // long delay so the reverse test never reaches trip
    bus(1'b1, ADR_OPD, 32'h00000028);
    bus(1'b1, ADR_CTRL, 32'h00000131);
    pw <= -24'sh002EE0;
    waitc(CC_START, 3 * PC);
    pw <= -24'sh002648;
    repeat (4 * PC) @(posedge i_clk);
    chk(32'(o_cond), 32'(CC_START));
    pw <= -24'sh002580;
    waitc(CC_NORMAL, 2 * PC);
    // partial write keeps the upper bytes of the inhibit level
    i_byteenable <= 4'h1;
    bus(1'b1, ADR_LPB, 32'h000000AA);
    i_byteenable <= 4'hF;
    rdc(ADR_LPB, 32'h000013AA);
    // a dead load must not trip until power recovers past the reset value
    bus(1'b1, ADR_OPD, 32'h00000004);
    pw <= 24'sh000FA0;
    bus(1'b1, ADR_CTRL, 32'h00000170);
    waitc(CC_BLOCKED, 3 * PC);
    pw <= 24'sh001F40;
    repeat (8 * PC) @(posedge i_clk);
    rdc(ADR_STAT, 32'h0000000F);
    pw <= 24'sh0028A0;
    waitc(CC_NORMAL, 3 * PC);
    test_done();
  end
endmodule
`default_nettype wire
